// ==== bridge_err_monitor.sv ====
// Port checks for the bridge error block, bound to its top module.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/10ps
module bridge_err_monitor (
   input wire sys_clk_in,
   input wire rst_in,
   input wire cfg_wr_in,
   input wire hub_hdr_err_in,
   input wire hub_hdr_sbe_in,
   input wire hub_hdr_to_bridge_in,
   input wire hub_cfg_wr_dpe_in,
   input wire hub_wr_dpe_in,
   input wire hub_wr_to_bridge_in,
   input wire hub_sbe_in,
   input wire pci_addr_pe_in,
   input wire pci_mem_cycle_in,
   input wire pci_tgt_wr_dpe_in,
   input wire serr_ack_in,
   input wire hub_cycle_abort_out,
   input wire hub_cycle_fwd_good_par_out,
   input wire pci_cycle_accept_out,
   input wire cfg_wr_discard_out,
   input wire poison_to_hub_out,
   input wire mem_wr_drop_out,
   input wire pci_parity_error_pin_oe_out,
   input wire system_error_message_cycle_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   a_abort_on_hdr: assert property (hub_cycle_abort_out |-> $past(hub_hdr_err_in && !hub_hdr_sbe_in))
      else $error("abort without header error");
   a_fwd_not_abort: assert property (hub_cycle_fwd_good_par_out |-> !hub_cycle_abort_out &&
      $past(hub_hdr_err_in && hub_hdr_to_bridge_in))
      else $error("bad good-parity forward");
   a_accept_mem: assert property ($past(pci_addr_pe_in && pci_mem_cycle_in) |-> pci_cycle_accept_out)
      else $error("memory cycle with address error not accepted");
   a_discard_cfg: assert property (cfg_wr_discard_out |-> $past(cfg_wr_in && hub_cfg_wr_dpe_in))
      else $error("discard without config data error");
   a_drop_nonbridge: assert property (mem_wr_drop_out |->
      $past(hub_wr_dpe_in && !hub_wr_to_bridge_in && !hub_sbe_in))
      else $error("bad write drop");
   a_perr_two_cycles: assert property ($rose(pci_parity_error_pin_oe_out) |-> $past(pci_tgt_wr_dpe_in, 2))
      else $error("parity pin not two cycles after data phase");
   a_perr_after_poison: assert property ($rose(pci_parity_error_pin_oe_out) |-> $past(poison_to_hub_out))
      else $error("parity pin without poison");
   a_msg_holds: assert property (system_error_message_cycle_out && !serr_ack_in |=>
      system_error_message_cycle_out)
      else $error("message dropped before ack");
endmodule // bridge_err_monitor
bind bridge_parity_error_reporting bridge_err_monitor mon (.*);

// ==== bridge_err_regs.vh ====
// Register offsets, bit positions and reset values for the bridge error logic.
// Assumes a 16-bit configuration register path addressed by byte offset.
`ifndef BRIDGE_ERR_REGS_VH
`define BRIDGE_ERR_REGS_VH
`define OFS_PRI_CMD 8'h04
`define OFS_PRI_STS 8'h06
`define OFS_SEC_STS 8'h1e
`define OFS_BR_CTL 8'h3e
`define RST_REG16 16'h0000
// Primary command bits
`define CMD_PAR_RESP 6
`define CMD_SERR_EN 8
// Status bits, shared by primary and secondary status
`define STS_DATA_PAR 8
`define STS_RCV_MABORT 13
`define STS_SIG_SERR 14
`define STS_RCV_SERR 14
`define STS_DET_PAR 15
// Bridge control bits
`define BC_PAR_RESP 0
`define BC_SERR_EN 1
`define BC_MABORT_MODE 5
`define BC_TMO_SERR_EN 11
// Writable masks
`define CMD_WMASK 16'h0140
`define BC_WMASK 16'h0823
`define STS_W1C_MASK 16'he100
`define PERR_DELAY 2'h2
`endif

// ==== bridge_parity_error_reporting.v ====
// Error detection and reporting for the hub to PCI bridge function.
// Assumes event inputs are one-cycle pulses synchronous to sys_clk_in and that
// the hub controller routes the system error message to processor alerting logic.
`timescale 1ns/10ps
`include "bridge_err_regs.vh"
module bridge_parity_error_reporting (
   input wire sys_clk_in,
   input wire rst_in,
   // Configuration register port
   input wire cfg_wr_in,
   input wire [7:0] cfg_addr_in,
   input wire [15:0] cfg_wdata_in,
   output reg [15:0] cfg_rdata_out,
   // Hub side events
   input wire hub_hdr_err_in,
   input wire hub_hdr_sbe_in,
   input wire hub_hdr_to_bridge_in,
   input wire hub_cfg_wr_dpe_in,
   input wire hub_cpl_dpe_in,
   input wire hub_wr_dpe_in,
   input wire hub_wr_to_bridge_in,
   input wire hub_sbe_in,
   // PCI side events, then the hub side message ack
   input wire pci_addr_pe_in,
   input wire pci_mem_cycle_in,
   input wire pci_rd_dpe_in,
   input wire pci_tgt_wr_dpe_in,
   input wire pci_parity_error_pin_in,
   input wire pci_wr_from_hub_err_in,
   input wire pci_system_error_pin_in,
   input wire dt_timeout_in,
   input wire posted_mabort_in,
   input wire special_cycle_in,
   input wire serr_ack_in,
   // Actions
   output reg hub_cycle_abort_out,
   output reg hub_cycle_fwd_good_par_out,
   output reg pci_cycle_accept_out,
   output reg cfg_wr_discard_out,
   output reg poison_to_hub_out,
   output reg poison_to_pci_out,
   output reg mem_wr_drop_out,
   output reg pci_parity_error_pin_n_out,
   output reg pci_parity_error_pin_oe_out,
   output wire system_error_message_cycle_out
);
   reg [15:0] pri_cmd_ff;
   reg [15:0] pri_sts_ff;
   reg [15:0] sec_sts_ff;
   reg [15:0] br_ctl_ff;
   reg [15:0] nxt_pri_sts;
   reg [15:0] nxt_sec_sts;
   reg [1:0] perr_cnt_ff;
   reg serr_req;
   wire pri_resp;
   wire pri_serr;
   wire sec_resp;
   wire hub_hdr_bad;
   wire hub_wr_bad;
   wire hub_cpl_bad;

   // Register write select, reused for every register
   function sel;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         sel = (addr == ofs);
      end
   endfunction

   assign pri_resp = pri_cmd_ff[`CMD_PAR_RESP];
   assign pri_serr = pri_cmd_ff[`CMD_SERR_EN];
   assign sec_resp = br_ctl_ff[`BC_PAR_RESP];
   // Single-bit ECC errors are corrected upstream and suppress header, write and completion errors
   assign hub_hdr_bad = hub_hdr_err_in & ~hub_hdr_sbe_in;
   assign hub_wr_bad = hub_wr_dpe_in & ~hub_sbe_in;
   assign hub_cpl_bad = hub_cpl_dpe_in & ~hub_sbe_in;

   always @* begin
      nxt_pri_sts = pri_sts_ff;
      nxt_sec_sts = sec_sts_ff;
      serr_req = 1'b0;
      // Software clears first so hardware set wins in the same cycle
      if (cfg_wr_in && sel(cfg_addr_in, `OFS_PRI_STS)) begin
         nxt_pri_sts = nxt_pri_sts & ~(cfg_wdata_in & `STS_W1C_MASK);
      end
      if (cfg_wr_in && sel(cfg_addr_in, `OFS_SEC_STS)) begin
         nxt_sec_sts = nxt_sec_sts & ~(cfg_wdata_in & `STS_W1C_MASK);
      end
      if (hub_hdr_bad) begin
         nxt_pri_sts[`STS_DET_PAR] = 1'b1;
         if (pri_resp && pri_serr) begin
            serr_req = 1'b1;
         end
      end
      if (pci_addr_pe_in) begin
         nxt_sec_sts[`STS_DET_PAR] = 1'b1;
         if (sec_resp && pri_serr && br_ctl_ff[`BC_SERR_EN]) begin
            serr_req = 1'b1;
         end
      end
      if (hub_cfg_wr_dpe_in) begin
         nxt_pri_sts[`STS_DET_PAR] = 1'b1;
         if (pri_resp) begin
            serr_req = 1'b1;
         end
      end
      if (pci_rd_dpe_in) begin
         nxt_sec_sts[`STS_DET_PAR] = 1'b1;
         if (sec_resp) begin
            nxt_sec_sts[`STS_DATA_PAR] = 1'b1;
         end
      end
      if (hub_cpl_bad) begin
         nxt_pri_sts[`STS_DET_PAR] = 1'b1;
         if (pri_resp) begin
            nxt_pri_sts[`STS_DATA_PAR] = 1'b1;
            serr_req = 1'b1;
         end
      end
      if (hub_wr_bad) begin
         nxt_pri_sts[`STS_DET_PAR] = 1'b1;
         if (pri_resp) begin
            serr_req = 1'b1;
         end
      end
      if (pci_tgt_wr_dpe_in) begin
         nxt_sec_sts[`STS_DET_PAR] = 1'b1;
      end
      if (pci_parity_error_pin_in) begin
         if (sec_resp) begin
            nxt_sec_sts[`STS_DATA_PAR] = 1'b1;
         end
         if (pri_serr && sec_resp && pri_resp && !pci_wr_from_hub_err_in) begin
            serr_req = 1'b1;
         end
      end
      if (pci_system_error_pin_in) begin
         nxt_sec_sts[`STS_RCV_SERR] = 1'b1;
         if (br_ctl_ff[`BC_SERR_EN] && pri_serr) begin
            serr_req = 1'b1;
         end
      end
      if (dt_timeout_in && pri_serr && br_ctl_ff[`BC_TMO_SERR_EN]) begin
         serr_req = 1'b1;
      end
      if (posted_mabort_in && !special_cycle_in) begin
         nxt_sec_sts[`STS_RCV_MABORT] = 1'b1;
         if (br_ctl_ff[`BC_MABORT_MODE]) begin
            serr_req = 1'b1;
         end
      end
      if (serr_req) begin
         nxt_pri_sts[`STS_SIG_SERR] = 1'b1;
      end
   end

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pri_cmd_ff <= `RST_REG16;
         br_ctl_ff <= `RST_REG16;
         pri_sts_ff <= `RST_REG16;
         sec_sts_ff <= `RST_REG16;
      end else begin
         pri_sts_ff <= nxt_pri_sts;
         sec_sts_ff <= nxt_sec_sts;
         // Command and bridge control writes with a data error are dropped when response is on; status clears still apply
         if (cfg_wr_in && !(hub_cfg_wr_dpe_in && pri_resp)) begin
            if (sel(cfg_addr_in, `OFS_PRI_CMD)) begin
               pri_cmd_ff <= cfg_wdata_in & `CMD_WMASK;
            end
            if (sel(cfg_addr_in, `OFS_BR_CTL)) begin
               br_ctl_ff <= cfg_wdata_in & `BC_WMASK;
            end
         end
      end
   end

   // Read data and action strobes, all registered
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_rdata_out <= `RST_REG16;
         hub_cycle_abort_out <= 1'b0;
         hub_cycle_fwd_good_par_out <= 1'b0;
         pci_cycle_accept_out <= 1'b0;
         cfg_wr_discard_out <= 1'b0;
         poison_to_hub_out <= 1'b0;
         poison_to_pci_out <= 1'b0;
         mem_wr_drop_out <= 1'b0;
      end else begin
         case (cfg_addr_in)
            `OFS_PRI_CMD: cfg_rdata_out <= pri_cmd_ff;
            `OFS_PRI_STS: cfg_rdata_out <= pri_sts_ff;
            `OFS_SEC_STS: cfg_rdata_out <= sec_sts_ff;
            `OFS_BR_CTL: cfg_rdata_out <= br_ctl_ff;
            default: cfg_rdata_out <= `RST_REG16;
         endcase
         hub_cycle_abort_out <= hub_hdr_bad & pri_resp;
         hub_cycle_fwd_good_par_out <= hub_hdr_bad & ~pri_resp & hub_hdr_to_bridge_in;
         // With response off the address error is ignored; memory cycles accepted either way
         pci_cycle_accept_out <= pci_addr_pe_in & (~sec_resp | pci_mem_cycle_in);
         cfg_wr_discard_out <= hub_cfg_wr_dpe_in & pri_resp;
         poison_to_hub_out <= pci_rd_dpe_in | pci_tgt_wr_dpe_in;
         poison_to_pci_out <= hub_cpl_bad | (hub_wr_bad & hub_wr_to_bridge_in);
         mem_wr_drop_out <= hub_wr_bad & ~hub_wr_to_bridge_in;
      end
   end

   // Parity error pin, one clock low, two cycles after the data phase
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         perr_cnt_ff <= 2'h0;
         pci_parity_error_pin_n_out <= 1'b1;
         pci_parity_error_pin_oe_out <= 1'b0;
      end else begin
         if (pci_tgt_wr_dpe_in && sec_resp) begin
            perr_cnt_ff <= `PERR_DELAY - 2'h1;
         end else if (perr_cnt_ff != 2'h0) begin
            perr_cnt_ff <= perr_cnt_ff - 2'h1;
         end
         pci_parity_error_pin_n_out <= ~(perr_cnt_ff == 2'h1);
         pci_parity_error_pin_oe_out <= (perr_cnt_ff == 2'h1);
      end
   end

   serr_message_gen u_serr (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .req_in(serr_req),
      .ack_in(serr_ack_in),
      .msg_req_out(system_error_message_cycle_out)
   );
endmodule // bridge_parity_error_reporting

// ==== hub_serr_partner.sv ====
// Hub side model acknowledging system error message cycles.
// Assumes a level request held until one ack pulse; alternates fast and slow.
`timescale 1ns/10ps
module hub_serr_partner (
   input wire sys_clk_in,
   input wire rst_in,
   input wire msg_in,
   output reg ack_out
);
   reg [2:0] wait_ff;
   reg slow_ff;
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wait_ff <= 3'h0;
         slow_ff <= 1'b0;
         ack_out <= 1'b0;
      end else if (ack_out || !msg_in) begin
         ack_out <= 1'b0;
         wait_ff <= 3'h0;
      end else if (wait_ff == (slow_ff ? 3'h5 : 3'h1)) begin
         ack_out <= 1'b1;
         slow_ff <= ~slow_ff;
      end else begin
         wait_ff <= wait_ff + 3'h1;
      end
   end
endmodule // hub_serr_partner

// ==== serr_message_gen.v ====
// Turns qualified system error requests into single message cycle requests.
// Assumes the hub side acknowledges each request with a one-cycle pulse.
`timescale 1ns/10ps
module serr_message_gen (
   input wire sys_clk_in,
   input wire rst_in,
   input wire req_in,
   input wire ack_in,
   output reg msg_req_out
);
   // Requests during a pending message merge into it
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         msg_req_out <= 1'b0;
      end else if (msg_req_out) begin
         if (ack_in) begin
            msg_req_out <= 1'b0;
         end
      end else if (req_in) begin
         msg_req_out <= 1'b1;
      end
   end
endmodule // serr_message_gen

// ==== tb_top.sv ====
// Self-checking bench for the bridge error reporting block.
// Assumes the register header and a hub partner acking message cycles.
`timescale 1ns/10ps
`include "bridge_err_regs.vh"
module tb_top;
   reg sys_clk_in = 1'b0;
   reg rst_in = 1'b1;
   reg cfg_wr = 1'b0;
   reg [7:0] cfg_addr = 8'h00;
   reg [15:0] cfg_wdata = 16'h0000;
   reg [17:0] ev = 18'h00000;
   reg [15:0] lfsr = 16'h000c;
   reg msg_prev = 1'b0;
   reg [7:0] act;
   reg [7:0] exp_q [$];
   integer miscompares = 0;
   integer n_compared = 0;
   integer perr_low = 0;
   integer i, p;
   wire [15:0] rdata;
   wire ab, fw, ac, dc, ph, pp, dr, msg, ack, perr_n, perr_oe;
   // Entries: events, expected actions with enables on, then off
   localparam bit [33:0] TBL [17] = '{{18'h00005, 8'h81, 8'h40}, {18'h00003, 8'h00, 8'h00},
      {18'h08001, 8'h81, 8'h00}, {18'h00010, 8'h05, 8'h04}, {18'h00090, 8'h00, 8'h00}, {18'h00060, 8'h05, 8'h04},
      {18'h00020, 8'h03, 8'h02}, {18'h00300, 8'h21, 8'h20}, {18'h00400, 8'h08, 8'h08}, {18'h00800, 8'h08, 8'h08},
      {18'h01000, 8'h01, 8'h00}, {18'h03000, 8'h00, 8'h00}, {18'h04000, 8'h01, 8'h00}, {18'h08000, 8'h01, 8'h00},
      {18'h10000, 8'h01, 8'h00}, {18'h30000, 8'h00, 8'h00}, {18'h00100, 8'h01, 8'h20}};
   bridge_parity_error_reporting dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr),
      .cfg_addr_in(cfg_addr), .cfg_wdata_in(cfg_wdata), .cfg_rdata_out(rdata), .hub_hdr_err_in(ev[0]),
      .hub_hdr_sbe_in(ev[1]), .hub_hdr_to_bridge_in(ev[2]), .hub_cfg_wr_dpe_in(ev[3]), .hub_cpl_dpe_in(ev[4]),
      .hub_wr_dpe_in(ev[5]), .hub_wr_to_bridge_in(ev[6]), .hub_sbe_in(ev[7]), .pci_addr_pe_in(ev[8]),
      .pci_mem_cycle_in(ev[9]), .pci_rd_dpe_in(ev[10]), .pci_tgt_wr_dpe_in(ev[11]), .pci_parity_error_pin_in(ev[12]),
      .pci_wr_from_hub_err_in(ev[13]), .pci_system_error_pin_in(ev[14]), .dt_timeout_in(ev[15]),
      .posted_mabort_in(ev[16]), .special_cycle_in(ev[17]), .serr_ack_in(ack), .hub_cycle_abort_out(ab),
      .hub_cycle_fwd_good_par_out(fw), .pci_cycle_accept_out(ac), .cfg_wr_discard_out(dc),
      .poison_to_hub_out(ph), .poison_to_pci_out(pp), .mem_wr_drop_out(dr), .pci_parity_error_pin_n_out(perr_n),
      .pci_parity_error_pin_oe_out(perr_oe), .system_error_message_cycle_out(msg));
   hub_serr_partner hub (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .msg_in(msg), .ack_out(ack));
   initial begin
      forever #10 sys_clk_in = ~sys_clk_in;
   end
   task bad(input [15:0] got, input [15:0] want);
      miscompares = miscompares + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
   endtask
   function [15:0] lfsr_next(input [15:0] v);
      lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task wr_reg(input [7:0] a, input [15:0] d, input [17:0] e);
      @(posedge sys_clk_in);
      #1 cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      ev = e;
      @(posedge sys_clk_in);
      #1 cfg_wr = 1'b0;
      ev = 18'h00000;
   endtask
   task rd_chk(input [7:0] a, input [15:0] e);
      @(posedge sys_clk_in);
      #1 cfg_addr = a;
      @(posedge sys_clk_in);
      #1 n_compared = n_compared + 1;
      if (rdata !== e) bad(rdata, e);
   endtask
   task pulse(input [17:0] e, input [7:0] x);
      if (x != 8'h00) exp_q.push_back(x);
      @(posedge sys_clk_in);
      #1 ev = e;
      @(posedge sys_clk_in);
      #1 ev = 18'h00000;
      repeat (10) @(posedge sys_clk_in);
   endtask
   // Outputs settle well before the falling edge
   always @(negedge sys_clk_in) begin
      act = {ab, fw, ac, dc, ph, pp, dr, msg & ~msg_prev};
      msg_prev = msg;
      if (perr_oe === 1'b1 && perr_n === 1'b0) perr_low = perr_low + 1;
      if (act !== 8'h00) begin
         n_compared = n_compared + 1;
         if (exp_q.size() == 0) bad({8'h00, act}, 16'h0000);
         else if (act !== exp_q.pop_front()) bad({8'h00, act}, 16'hffff);
      end
   end
   task give_verdict;
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge sys_clk_in);
      miscompares = miscompares + 1;
      give_verdict;
   end
   initial begin
      repeat (4) @(posedge sys_clk_in);
      #1 rst_in = 1'b0;
      rd_chk(8'h10, 16'h0000);
      rd_chk(`OFS_PRI_STS, `RST_REG16);
      for (i = 0; i < 4; i = i + 1) begin
         lfsr = lfsr_next(lfsr);
         wr_reg(`OFS_PRI_CMD, lfsr, 18'h00000);
         rd_chk(`OFS_PRI_CMD, lfsr & `CMD_WMASK);
         wr_reg(`OFS_BR_CTL, ~lfsr, 18'h00000);
         rd_chk(`OFS_BR_CTL, ~lfsr & `BC_WMASK);
      end
      for (p = 0; p < 2; p = p + 1) begin
         wr_reg(`OFS_PRI_CMD, p ? 16'h0000 : 16'hffff, 18'h00000);
         wr_reg(`OFS_BR_CTL, p ? 16'h0000 : 16'hffff, 18'h00000);
         for (i = 0; i < 17; i = i + 1) begin
            pulse(TBL[i][33:16], p ? TBL[i][7:0] : TBL[i][15:8]);
         end
         if (p == 0) begin
            exp_q.push_back(8'h11);
            wr_reg(`OFS_PRI_CMD, 16'h0000, 18'h00008);
            rd_chk(`OFS_PRI_CMD, `CMD_WMASK);
         end
         rd_chk(`OFS_PRI_STS, p ? 16'h8000 : 16'hc100);
         rd_chk(`OFS_SEC_STS, p ? 16'he000 : 16'he100);
         wr_reg(`OFS_PRI_STS, 16'hffff, 18'h00000);
         // Clear and a new read data error in one cycle: the set must win
         exp_q.push_back(8'h08);
         wr_reg(`OFS_SEC_STS, 16'hffff, 18'h00400);
         rd_chk(`OFS_SEC_STS, p ? 16'h8000 : 16'h8100);
         wr_reg(`OFS_SEC_STS, 16'hffff, 18'h00000);
         rd_chk(`OFS_SEC_STS, 16'h0000);
         rd_chk(`OFS_PRI_STS, 16'h0000);
      end
      n_compared = n_compared + 1;
      if (perr_low !== 1) bad(perr_low[15:0], 16'h0001);
      if (exp_q.size() != 0) bad(exp_q.size(), 16'h0000);
      give_verdict;
   end
endmodule // tb_top
